/* logic/adc_read_pkg.sv */
// constants and carrier types for the converter serial read-out port.
// assumes a 125 MHz system clock; all times below are in ns.
package adc_read_pkg;

  localparam int unsigned CLK_NS = 8;
  // conversion length, its pre-end point and read start delays
  localparam int unsigned T_CONV_NS = 400;
  localparam int unsigned T_PRE_END_NS = 40;
  localparam int unsigned T_RD_SYNC_NS = 16;
  localparam int unsigned T_EOC_SYNC_NS = 16;
  localparam int unsigned T_RESTRICT_NS = 24;
  // least times round up
  localparam int unsigned CONV_CYC = (T_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PRE_END_CYC =
    (T_PRE_END_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_SYNC_CYC =
    (T_RD_SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned EOC_SYNC_CYC =
    (T_EOC_SYNC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RESTRICT_CYC =
    (T_RESTRICT_NS + CLK_NS - 1) / CLK_NS;

  localparam int unsigned RES_W = 16;
  localparam logic [4:0] MSB_EDGE = 5'h02;
  localparam logic [4:0] LSB_EDGE = 5'h11;
  localparam logic [4:0] END_EDGE = 5'h12;
  localparam logic [4:0] WORD_EDGE = 5'h10;
  localparam logic [4:0] BYTE_EDGE = 5'h08;
  localparam logic [4:0] BUSY_DROP_CNT = 5'h0f;

  typedef enum logic {TOPO_DAISY, TOPO_CASCADE} topo_t;

  // pins that arrive from outside the clock domain
  typedef struct packed {
    logic link_clk;
    logic rd_n;
    logic cs_n;
    logic trig_n;
    logic ser_in;
    logic sync_in;
  } pins_t;

endpackage

/* logic/adc_lvds_serial_read_port.sv */
// serial read-out engine of the converter: framing, read start, chaining.
// assumes link clock at most a quarter of clk_i; result_i is sampled on
// the clk_i domain at conversion end.
//
// Notes on behaviour
// - request falls, chip select low, wait or sample phase: start read
// - read start releases data and sync, raises bus occupied
// - word framing: sync repeats every 16 link clocks
// - bit counting starts after the link clock edge that raised sync
// - msb on second rising edge, one bit per rising edge after
// - word framing: next sync on 16th rise, lsb on 17th
// - chip select high mid-read floats outputs until next read
// - byte framing: sync every 8 clocks, bit 8 on 9th rise
// - start from wait or sample: sync low, rises fixed delay later
// - request before pre-end point starts read at that point
// - conversion-end start: sync rises fixed delay after conversion
// - lsb on 17th rise, outputs float on 18th rise
// - daisy chain: bus occupied falls before the ending sync rise
// - cascade: bus occupied falls after outputs float
// - no start in window near conversion end; result picks by side
// - non-first device forwards link until request falls, then appends
// - trigger rise samples, fall converts fixed time, busy while converting
`timescale 1ns/1ns
module adc_lvds_serial_read_port (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic read_req_n_i,
  input wire logic chip_sel_n_i,
  input wire logic conversion_trigger_n_i,
  input wire logic serial_data_in_i,
  input wire logic sync_in_i,
  input wire logic byte_frame_i,
  input wire logic topology_i,
  input wire logic chain_position_select_i,
  input wire logic [15:0] result_i,
  output logic link_clk_o,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  output logic frame_sync_o,
  output logic frame_sync_oe_o,
  output logic bus_busy_o,
  output logic conversion_busy_o
);

  typedef enum logic [1:0] {PH_WAIT, PH_SAMPLE, PH_CONV} phase_t;
  typedef enum logic [2:0] {R_IDLE, R_FWD, R_START, R_SHIFT, R_TAIL}
    rd_state_t;

  // ==========================================================
  // pin synchronisers and edge detection
  adc_read_pkg::pins_t pin_raw;
  adc_read_pkg::pins_t s1_q;
  adc_read_pkg::pins_t s2_q;
  adc_read_pkg::pins_t s3_q;

  assign pin_raw = '{link_clk: link_clk_i, rd_n: read_req_n_i,
                     cs_n: chip_sel_n_i, trig_n: conversion_trigger_n_i,
                     ser_in: serial_data_in_i, sync_in: sync_in_i};

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else if (ce_i)
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic lrise, lfall, rd_fall, rd_rise;
  logic trig_rise, trig_fall, cs_hi;

  assign lrise = s2_q.link_clk && !s3_q.link_clk;
  assign lfall = !s2_q.link_clk && s3_q.link_clk;
  assign rd_fall = !s2_q.rd_n && s3_q.rd_n;
  assign rd_rise = s2_q.rd_n && !s3_q.rd_n;
  assign trig_rise = s2_q.trig_n && !s3_q.trig_n;
  assign trig_fall = !s2_q.trig_n && s3_q.trig_n;
  assign cs_hi = s2_q.cs_n;

  // ==========================================================
  // sample and conversion sequencing
  phase_t phase_q;
  logic [7:0] conv_cnt_q;
  logic [7:0] post_q;
  logic samp_pend_q;
  logic [15:0] result_q;
  logic conv_done;
  logic pre_end;
  logic in_window;

  assign conv_done = phase_q == PH_CONV && conv_cnt_q == 8'h01;
  assign pre_end = phase_q == PH_CONV &&
    conv_cnt_q == 8'(adc_read_pkg::PRE_END_CYC);
  // the result register flips at conversion end, so starts too close to
  // it could see either word; they are refused instead
  assign in_window = (phase_q == PH_CONV &&
    conv_cnt_q < 8'(adc_read_pkg::PRE_END_CYC)) || post_q != 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      phase_q <= PH_WAIT;
      conv_cnt_q <= 8'h00;
      post_q <= 8'h00;
      samp_pend_q <= 1'b0;
      result_q <= 16'h0000;
      conversion_busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (post_q != 8'h00)
        post_q <= post_q - 8'h01;
      if (trig_fall && phase_q != PH_WAIT)
      begin
        // a fall during conversion aborts it and starts over
        phase_q <= PH_CONV;
        conv_cnt_q <= 8'(adc_read_pkg::CONV_CYC);
        conversion_busy_o <= 1'b1;
        samp_pend_q <= 1'b0;
      end
      else if (conv_done)
      begin
        result_q <= result_i;
        conversion_busy_o <= 1'b0;
        post_q <= 8'(adc_read_pkg::RESTRICT_CYC);
        phase_q <= (samp_pend_q || trig_rise) ? PH_SAMPLE : PH_WAIT;
        samp_pend_q <= 1'b0;
      end
      else
      begin
        if (phase_q == PH_CONV)
          conv_cnt_q <= conv_cnt_q - 8'h01;
        if (trig_rise && phase_q == PH_WAIT)
          phase_q <= PH_SAMPLE;
        else if (trig_rise && phase_q == PH_CONV)
          samp_pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read cycle control and serialiser
  rd_state_t rd_st_q;
  logic [4:0] cnt_q;
  logic [4:0] cnt_n;
  logic [7:0] dly_q;
  logic [15:0] shift_q;
  logic start_rd, start_eoc, start_own, start_fwd;

  assign start_rd = rd_fall && !cs_hi && !in_window &&
    (phase_q != PH_CONV || rd_st_q == R_FWD);
  // level check so a request held low also starts at the pre-end point
  assign start_eoc = pre_end && !s2_q.rd_n && !cs_hi &&
    rd_st_q == R_IDLE;
  assign start_own = ce_i && (rd_st_q == R_IDLE || rd_st_q == R_FWD) &&
    (start_rd || start_eoc);
  assign start_fwd = ce_i && rd_st_q == R_IDLE && rd_rise && !cs_hi &&
    chain_position_select_i && !start_own;
  assign cnt_n = cnt_q + 5'h01;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      link_clk_o <= 1'b0;
    else if (ce_i)
      link_clk_o <= s2_q.link_clk;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_st_q <= R_IDLE;
      cnt_q <= 5'h00;
      dly_q <= 8'h00;
      shift_q <= 16'h0000;
      serial_data_out_o <= 1'b0;
      serial_data_out_oe_o <= 1'b0;
      frame_sync_o <= 1'b0;
      frame_sync_oe_o <= 1'b0;
      bus_busy_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (cs_hi && rd_st_q != R_IDLE)
      begin
        // halt: float and stay floating until a fresh start
        rd_st_q <= R_IDLE;
        serial_data_out_oe_o <= 1'b0;
        frame_sync_oe_o <= 1'b0;
        frame_sync_o <= 1'b0;
        bus_busy_o <= 1'b0;
      end
      else if (start_own)
      begin
        rd_st_q <= R_START;
        bus_busy_o <= 1'b1;
        serial_data_out_oe_o <= 1'b1;
        frame_sync_oe_o <= 1'b1;
        frame_sync_o <= 1'b0;
        serial_data_out_o <= 1'b0;
        dly_q <= start_eoc ?
          8'(adc_read_pkg::PRE_END_CYC + adc_read_pkg::EOC_SYNC_CYC) :
          8'(adc_read_pkg::RD_SYNC_CYC);
      end
      else if (start_fwd)
      begin
        rd_st_q <= R_FWD;
        bus_busy_o <= 1'b1;
        serial_data_out_oe_o <= 1'b1;
        frame_sync_oe_o <= 1'b1;
      end
      else
      begin
        unique case (rd_st_q)
          R_IDLE: ;
          R_FWD:
          begin
            serial_data_out_o <= s2_q.ser_in;
            frame_sync_o <= s2_q.sync_in;
          end
          R_START:
          begin
            if (dly_q != 8'h00)
              dly_q <= dly_q - 8'h01;
            else if (lrise)
            begin
              // newest completed result, taken when the frame opens
              shift_q <= result_q;
              frame_sync_o <= 1'b1;
              cnt_q <= 5'h00;
              rd_st_q <= R_SHIFT;
            end
          end
          R_SHIFT:
          begin
            if (lrise)
            begin
              cnt_q <= cnt_n;
              frame_sync_o <= cnt_n == adc_read_pkg::WORD_EDGE ||
                (byte_frame_i &&
                cnt_n == adc_read_pkg::BYTE_EDGE);
              if (cnt_n >= adc_read_pkg::MSB_EDGE &&
                  cnt_n <= adc_read_pkg::LSB_EDGE)
              begin
                serial_data_out_o <= shift_q[15];
                shift_q <= {shift_q[14:0], 1'b0};
              end
              if (cnt_n == adc_read_pkg::END_EDGE)
              begin
                serial_data_out_oe_o <= 1'b0;
                frame_sync_oe_o <= 1'b0;
                frame_sync_o <= 1'b0;
                serial_data_out_o <= 1'b0;
                rd_st_q <= topology_i ? R_TAIL : R_IDLE;
              end
            end
            else if (lfall && cnt_q == adc_read_pkg::BUSY_DROP_CNT &&
                     topology_i == adc_read_pkg::TOPO_DAISY)
              bus_busy_o <= 1'b0;
          end
          R_TAIL:
          begin
            bus_busy_o <= 1'b0;
            rd_st_q <= R_IDLE;
          end
          default:
            rd_st_q <= R_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_start_drive:
    assert property (start_own && !cs_hi |=> bus_busy_o &&
      serial_data_out_oe_o && frame_sync_oe_o)
    else $error("read start did not drive outputs");
  a_sync_low_start:
    assert property ($rose(frame_sync_oe_o) |-> !frame_sync_o)
    else $error("sync not low at read start");
  a_msb_second_rise:
    assert property (ce_i && !cs_hi && rd_st_q == R_SHIFT && lrise &&
      cnt_q == 5'h01 |=> serial_data_out_o == $past(shift_q[15]))
    else $error("msb not driven on second rise");
  a_word_sync:
    assert property (ce_i && !cs_hi && rd_st_q == R_SHIFT && lrise &&
      cnt_q == 5'h0f |=> frame_sync_o)
    else $error("sync missing on 16th rise");
  a_byte_sync:
    assert property (ce_i && !cs_hi && rd_st_q == R_SHIFT && lrise &&
      cnt_q == 5'h07 |=> frame_sync_o == $past(byte_frame_i))
    else $error("byte sync wrong on 8th rise");
  a_float_18:
    assert property (ce_i && !cs_hi && rd_st_q == R_SHIFT && lrise &&
      cnt_q == 5'h11 |=> !serial_data_out_oe_o && !frame_sync_oe_o)
    else $error("outputs not floated on 18th rise");
  a_cs_halt:
    assert property (ce_i && cs_hi && rd_st_q != R_IDLE |=>
      !serial_data_out_oe_o && !frame_sync_oe_o && !bus_busy_o)
    else $error("chip select halt ignored");
  a_cascade_busy:
    assert property ($fell(bus_busy_o) && topology_i |->
      !serial_data_out_oe_o)
    else $error("cascade busy fell while driving");
  a_daisy_busy:
    assert property ($fell(bus_busy_o) && !topology_i &&
      $past(!cs_hi) |-> frame_sync_oe_o ##1 !frame_sync_o)
    else $error("daisy busy fell at wrong time");
  a_conv_busy:
    assert property (ce_i && trig_fall && phase_q != PH_WAIT |=>
      conversion_busy_o [*8])
    else $error("conversion busy not held");

endmodule

/* tb/adc_rx_model.sv */
// receiver at the far end of the serial link: free link clock,
// shift on falls, frame count from the sync rise.
// assumes the port's outputs settle on clk_i edges.
`timescale 1ns/1ns
module adc_rx_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rx_clk_i,
  input wire logic rx_dat_i,
  input wire logic rx_dat_oe_i,
  input wire logic rx_sync_i,
  input wire logic rx_sync_oe_i,
  output logic lclk_o,
  output logic vld_o,
  output logic [15:0] word_o,
  output logic [4:0] per_o
);
  // ====
  // link clock, free running since the receiver needs it continuous
  initial
  begin
    lclk_o = 1'b0;
    forever #80 lclk_o = ~lclk_o;
  end
  // ====
  // deserialiser
  logic clk_q;
  logic sync_q;
  logic [4:0] cnt_q;
  logic s;
  logic rise;
  assign s = rx_sync_i & rx_sync_oe_i;
  assign rise = s & ~sync_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_q <= 1'b0;
      sync_q <= 1'b0;
      cnt_q <= 5'h1f;
      vld_o <= 1'b0;
      word_o <= 16'h0000;
      per_o <= 5'h00;
    end
    else
    begin
      clk_q <= rx_clk_i;
      vld_o <= 1'b0;
      // fall sampling keeps clear of the clk_i edge that moves data
      if (clk_q && !rx_clk_i)
      begin
        sync_q <= s;
        if (rx_dat_oe_i)
          word_o <= {word_o[14:0], rx_dat_i};
        if (rise)
        begin
          cnt_q <= 5'h00;
          per_o <= cnt_q + 5'h01;
        end
        else if (cnt_q != 5'h1f)
          cnt_q <= cnt_q + 5'h01;
        // second fall after a sync rise ends a word or a byte
        vld_o <= (cnt_q == 5'h00) && !rise;
      end
    end
  end
endmodule

/* tb/adc_lvds_serial_read_port_bench.sv */
// bench for the serial read-out port: word, byte, halt and
// end-of-conversion reads. assumes adc_rx_model drives the link clock.
`timescale 1ns/1ns
module adc_lvds_serial_read_port_bench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd_n = 1'b1;
  logic cs_n = 1'b0;
  logic trig_n = 1'b1;
  logic byte_m = 1'b0;
  logic topo = 1'b0;
  logic [15:0] res = 16'ha5c3;
  logic chain_m = 1'b0;
  logic ser_in = 1'b0;
  logic sync_in = 1'b0;
  logic lclk, lco, sdat, sdat_oe, fs, fs_oe, busy, cbusy, vld;
  logic [15:0] word;
  logic [4:0] per;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // ====
  // first device in the chain until the chain test moves it
  adc_lvds_serial_read_port uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link_clk_i(lclk),
    .read_req_n_i(rd_n), .chip_sel_n_i(cs_n),
    .conversion_trigger_n_i(trig_n), .serial_data_in_i(ser_in),
    .sync_in_i(sync_in), .byte_frame_i(byte_m), .topology_i(topo),
    .chain_position_select_i(chain_m),
    .result_i(res), .link_clk_o(lco), .serial_data_out_o(sdat),
    .serial_data_out_oe_o(sdat_oe), .frame_sync_o(fs),
    .frame_sync_oe_o(fs_oe), .bus_busy_o(busy), .conversion_busy_o(cbusy)
  );
  adc_rx_model rx (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rx_clk_i(lco), .rx_dat_i(sdat),
    .rx_dat_oe_i(sdat_oe), .rx_sync_i(fs), .rx_sync_oe_i(fs_oe),
    .lclk_o(lclk), .vld_o(vld), .word_o(word), .per_o(per)
  );
  // ====
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function logic sel(input int s);
    case (s)
      0: return busy;
      1: return vld;
      2: return fs_oe;
      default: return cbusy;
    endcase
  endfunction
  // waits are checked on the falling clk edge, clear of the updates
  task wt(input int s, input logic v, input int lim);
    for (int i = 0; i < lim; i++)
    begin
      @(negedge clk_i);
      if (sel(s) === v)
        return;
    end
    chk(1'b0, "wait ran out");
    test_done();
  endtask
  task conv();
    @(posedge clk_i);
    trig_n <= 1'b1;
    cyc(4);
    trig_n <= 1'b0;
    wt(3, 1'b1, 20);
    n = 1;
    while (cbusy === 1'b1 && n < 200)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(n - 1 == adc_read_pkg::CONV_CYC, "conversion length");
  endtask
  task rd_start();
    @(posedge clk_i);
    rd_n <= 1'b0;
    wt(0, 1'b1, 20);
    chk(fs_oe === 1'b1 && sdat_oe === 1'b1, "not released");
    chk(fs === 1'b0, "sync not low at start");
  endtask
  // ====
  initial
  begin
    cyc(12);
    rst_n_i <= 1'b1;
    cyc(3);
    trig_n <= 1'b0;
    cyc(8);
    conv();
    cyc(10);
    rd_start();
    wt(0, 1'b0, 1000);
    chk(fs_oe === 1'b1 && sdat_oe === 1'b1, "busy fell late");
    wt(1, 1'b1, 400);
    chk(word === 16'ha5c3, "word");
    chk(per === 5'h10, "word period");
    wt(2, 1'b0, 400);
    chk(sdat_oe === 1'b0, "data still driven");
    $display("test word done");
    @(posedge clk_i);
    rd_n <= 1'b1;
    byte_m <= 1'b1;
    topo <= 1'b1;
    cyc(20);
    rd_start();
    wt(1, 1'b1, 400);
    wt(1, 1'b1, 400);
    chk(word[7:0] === 8'ha5, "upper byte");
    wt(1, 1'b1, 400);
    chk(word[7:0] === 8'hc3, "lower byte");
    chk(per === 5'h08, "byte period");
    wt(0, 1'b0, 400);
    chk(sdat_oe === 1'b0 && fs_oe === 1'b0, "busy fell early");
    $display("test byte done");
    @(posedge clk_i);
    rd_n <= 1'b1;
    byte_m <= 1'b0;
    topo <= 1'b0;
    cyc(20);
    rd_start();
    cyc(60);
    cs_n <= 1'b1;
    wt(2, 1'b0, 10);
    chk(sdat_oe === 1'b0 && busy === 1'b0, "halt");
    cyc(200);
    chk(fs_oe === 1'b0 && sdat_oe === 1'b0, "halt left");
    rd_n <= 1'b1;
    $display("test halt done");
    cyc(20);
    rd_n <= 1'b0;
    cyc(20);
    cs_n <= 1'b0;
    res <= 16'h3c5a;
    cyc(20);
    chk(busy === 1'b0, "start without edge");
    conv();
    chk(busy === 1'b1, "no start at pre-end");
    wt(0, 1'b0, 1000);
    wt(1, 1'b1, 400);
    chk(word === 16'h3c5a, "current result");
    $display("test end of conversion done");
    // non-first device: forward while request is high, then own word
    wt(2, 1'b0, 400);
    @(posedge clk_i);
    rd_n <= 1'b1;
    chain_m <= 1'b1;
    ser_in <= 1'b1;
    sync_in <= 1'b1;
    wt(0, 1'b1, 20);
    cyc(6);
    chk(sdat === 1'b1 && fs === 1'b1 && fs_oe === 1'b1, "forward");
    ser_in <= 1'b0;
    sync_in <= 1'b0;
    cyc(20);
    rd_n <= 1'b0;
    wt(0, 1'b0, 1000);
    wt(1, 1'b1, 400);
    chk(word === 16'h3c5a, "own word after forward");
    $display("test chain done");
    test_done();
  end
endmodule
